// [include/frc_pkg.sv]
// Package: field layout, reset values and timing constants of the fault response controller
package frc_pkg;

  // ======================================================================
  // Response byte layout
  localparam int RESP_MSB = 7;
  localparam int RESP_LSB = 6;
  localparam int RETRY_MSB = 5;
  localparam int RETRY_LSB = 3;
  localparam int DELAY_MSB = 2;
  localparam int DELAY_LSB = 0;
  localparam logic [7:0] ACTION_RESET = 8'h80;

  // ======================================================================
  // Response and retry codes
  localparam logic [1:0] RESP_IGNORE = 2'h0;
  localparam logic [1:0] RESP_DELAY_OFF = 2'h1;
  localparam logic [1:0] RESP_SHUTDOWN = 2'h2;
  localparam logic [1:0] RESP_INHIBIT = 2'h3;
  localparam logic [2:0] RETRY_NONE = 3'h0;
  localparam logic [2:0] RETRY_ENDLESS = 3'h7;

  // ======================================================================
  // Timing: one delay unit, in microseconds, and its cycle count at 50 MHz
  localparam int CLK_MHZ = 50;
  localparam int UNIT_US = 1000;
  localparam int UNIT_CYCLES = UNIT_US * CLK_MHZ;

  // Decoded response byte
  typedef struct packed {
    logic [1:0] resp;
    logic [2:0] retry;
    logic [2:0] delay;
  } frc_action_t;

endpackage

// [core/frc_unit_tick.sv]
// Free-running delay-unit time base: one-cycle enable pulse per unit
`timescale 1ns/1ps
module frc_unit_tick #(
  parameter int UNIT_CYCLES = 50000
) (
  input wire logic clock,
  input wire logic nrst,
  output logic tick
);

  logic [31:0] cnt_reg;

  // ======================================================================
  // Divider; tick is registered and lasts exactly one cycle when UNIT_CYCLES is above 1
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= 32'h0;
      tick <= 1'b0;
    end else if (cnt_reg >= 32'(UNIT_CYCLES - 1)) begin
      cnt_reg <= 32'h0;
      tick <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 32'h1;
      tick <= 1'b0;
    end
  end

endmodule

// [core/frc_fault_response.sv]
// Fault response sequencer for one voltage or temperature fault
// Functional notes
// - Response byte holds response, retry, delay fields
// - Any response sets the matching fault flag
// - Any response also notifies the host
// - Flag stays set until a clearing event
// - Response 00: keep running without interruption
// - Response 01: run for delay count units
// - Response 01: fault at expiry latches off
// - Response 10: disable at once, follow retry
// - Response 11: output off only while fault
// - Retry 000: no restart, stay off
// - Retry 001-110: one to six restart attempts
// - All retries fail: stay off until cleared
// - Attempt spacing is delay count units
// - Retry 111: retry until off, bias, other fault
// - Delay field counts delay time units
// - Delay unit length depends on fault type
// - Clear by command, reset, off-on cycle, bias loss
// - Fault present at clear sets flag again
`timescale 1ns/1ps
module frc_fault_response #(
  parameter int UNIT_CYCLES = frc_pkg::UNIT_CYCLES
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic action_wr,
  input wire logic [7:0] action_wdata,
  input wire logic fault_in,
  input wire logic other_shutdown,
  input wire logic clear_faults,
  input wire logic output_cmd_on,
  input wire logic bias_ok,
  output logic [7:0] action_rdata,
  output logic fault_flag,
  output logic host_notify,
  output logic output_enable,
  output logic latched_off
);

  typedef enum logic [2:0] {
    FRC_RUN, FRC_DELAY_RUN, FRC_OFF_WAIT, FRC_RETRY, FRC_LATCHED, FRC_INHIBIT
  } frc_state_t;

  frc_state_t state_reg;
  frc_pkg::frc_action_t action_reg;
  logic [2:0] unit_cnt_reg;
  logic [2:0] tries_reg;
  logic fault_d_reg;
  logic cmd_on_d_reg;
  logic tick;
  logic fault_rise;
  logic restart_event;
  logic clear_event;
  logic interval_done;

  // ======================================================================
  // Delay unit time base; its length is set per fault type by the parameter
  frc_unit_tick #(
    .UNIT_CYCLES(UNIT_CYCLES)
  ) u_tick (
    .clock(clock),
    .nrst(nrst),
    .tick(tick)
  );

  // ======================================================================
  // Response setting register, written by the management bus
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      action_reg <= frc_pkg::ACTION_RESET;
    end else if (action_wr) begin
      action_reg <= frc_pkg::frc_action_t'(action_wdata);
    end
  end

  // Readback of the setting
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      action_rdata <= frc_pkg::ACTION_RESET;
    end else begin
      action_rdata <= action_reg;
    end
  end

  // ======================================================================
  // Event detection
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      fault_d_reg <= 1'b0;
      // Idle on level, so that releasing reset is not taken for an off-on edge
      cmd_on_d_reg <= 1'b1;
    end else begin
      fault_d_reg <= fault_in;
      cmd_on_d_reg <= output_cmd_on;
    end
  end

  assign fault_rise = fault_in && !fault_d_reg;
  // Off-then-on command edge permits a restart
  assign restart_event = output_cmd_on && !cmd_on_d_reg;
  assign clear_event = clear_faults || restart_event || !bias_ok;
  assign interval_done = tick && (unit_cnt_reg <= 3'h1);

  // ======================================================================
  // Fault flag: a present fault wins over any clear, so it re-sets at once
  // A clear in the same cycle as the fault therefore leaves the flag set
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      fault_flag <= 1'b0;
    end else if (fault_in) begin
      fault_flag <= 1'b1;
    end else if (clear_event) begin
      fault_flag <= 1'b0;
    end
  end

  // Host notification: one pulse per newly detected fault, whatever the response
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      host_notify <= 1'b0;
    end else begin
      host_notify <= fault_rise;
    end
  end

  // ======================================================================
  // Delay unit counter, reloaded on each new fault and each retry start
  // The time base runs free, so the first unit after a reload may be short by up
  // to one unit; restarting the divider instead would cost a second counter
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      unit_cnt_reg <= 3'h0;
    end else if (fault_rise || (state_reg == FRC_RETRY)) begin
      unit_cnt_reg <= action_reg.delay;
    end else if (tick && unit_cnt_reg != 3'h0) begin
      unit_cnt_reg <= unit_cnt_reg - 3'h1;
    end
  end

  // ======================================================================
  // Response sequencer
  // States:
  //   RUN       output follows the on command; a new fault picks a response
  //   DELAY_RUN keeps running for the delay count, then latches if the fault stays
  //   OFF_WAIT  output off, waiting one delay interval before the next attempt
  //   RETRY     one-cycle restart attempt; the fault being gone counts as success
  //   LATCHED   off until the output is commanded off and on again, or bias is lost
  //   INHIBIT   off while the fault lasts, back to RUN on its own
  // Off command and bias loss come first, so even endless retry can be stopped
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_reg <= FRC_RUN;
      tries_reg <= 3'h0;
    end else if (!bias_ok || !output_cmd_on) begin
      // Commanded off or bias lost stops everything, endless retry too
      state_reg <= FRC_RUN;
      tries_reg <= 3'h0;
    end else if (other_shutdown && state_reg != FRC_LATCHED) begin
      state_reg <= FRC_LATCHED;
    end else begin
      case (state_reg)
        FRC_RUN: begin
          tries_reg <= 3'h0;
          if (fault_rise) begin
            case (action_reg.resp)
              frc_pkg::RESP_IGNORE: state_reg <= FRC_RUN;
              frc_pkg::RESP_DELAY_OFF: state_reg <= FRC_DELAY_RUN;
              frc_pkg::RESP_SHUTDOWN: state_reg <= FRC_OFF_WAIT;
              default: state_reg <= FRC_INHIBIT;
            endcase
          end
        end
        FRC_DELAY_RUN: begin
          // Zero delay expires at once
          if (action_reg.delay == 3'h0 || interval_done) begin
            state_reg <= fault_in ? FRC_LATCHED : FRC_RUN;
          end
        end
        FRC_OFF_WAIT: begin
          if (action_reg.retry == frc_pkg::RETRY_NONE) begin
            state_reg <= FRC_LATCHED;
          end else if (action_reg.delay == 3'h0 || interval_done) begin
            if (action_reg.retry != frc_pkg::RETRY_ENDLESS && tries_reg >= action_reg.retry) begin
              state_reg <= FRC_LATCHED;
            end else begin
              state_reg <= FRC_RETRY;
              tries_reg <= tries_reg + 3'h1;
            end
          end
        end
        FRC_RETRY: begin
          // Attempt succeeds if the fault is gone; otherwise off again
          state_reg <= fault_in ? FRC_OFF_WAIT : FRC_RUN;
        end
        FRC_LATCHED: begin
          if (restart_event) begin
            state_reg <= FRC_RUN;
          end
        end
        FRC_INHIBIT: begin
          if (!fault_in) begin
            state_reg <= FRC_RUN;
          end
        end
        default: state_reg <= FRC_RUN;
      endcase
    end
  end

  // ======================================================================
  // Registered output drive
  // Registered so every pin changes on a clock edge only; costs one cycle of reaction
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      output_enable <= 1'b0;
      latched_off <= 1'b0;
    end else begin
      output_enable <= output_cmd_on && bias_ok &&
        (state_reg == FRC_RUN || state_reg == FRC_DELAY_RUN || state_reg == FRC_RETRY);
      latched_off <= (state_reg == FRC_LATCHED);
    end
  end

  // ======================================================================
  // Checks
  sequence s_fault_seen;
    fault_in;
  endsequence

  chk_flag_sets: assert property (@(posedge clock) disable iff (!nrst)
    s_fault_seen |=> fault_flag) else $error("fault flag not set");

  chk_flag_holds: assert property (@(posedge clock) disable iff (!nrst)
    (fault_flag && !clear_event) |=> fault_flag) else $error("fault flag dropped");

  chk_notify_pulse: assert property (@(posedge clock) disable iff (!nrst)
    fault_rise |=> host_notify) else $error("no host notification");

  chk_ignore_runs: assert property (@(posedge clock) disable iff (!nrst)
    (state_reg == FRC_RUN && fault_rise && action_reg.resp == frc_pkg::RESP_IGNORE
     && output_cmd_on && bias_ok && !other_shutdown && !action_wr) |=> state_reg == FRC_RUN)
    else $error("response 00 interrupted");

  chk_shutdown_now: assert property (@(posedge clock) disable iff (!nrst)
    (state_reg == FRC_RUN && fault_rise && action_reg.resp == frc_pkg::RESP_SHUTDOWN
     && output_cmd_on && bias_ok && !other_shutdown) |=> ##1 !output_enable)
    else $error("response 10 did not disable");

  chk_latch_stays: assert property (@(posedge clock) disable iff (!nrst)
    (state_reg == FRC_LATCHED && !restart_event && output_cmd_on && bias_ok) |=> state_reg == FRC_LATCHED)
    else $error("latched off released");

  chk_inhibit_free: assert property (@(posedge clock) disable iff (!nrst)
    (state_reg == FRC_INHIBIT && !fault_in && output_cmd_on && bias_ok && !other_shutdown)
    |=> state_reg == FRC_RUN) else $error("inhibit not released");

  chk_retry_bound: assert property (@(posedge clock) disable iff (!nrst)
    (action_reg.retry != frc_pkg::RETRY_ENDLESS && !action_wr) |-> tries_reg <= action_reg.retry)
    else $error("too many retries");

  chk_no_retry: assert property (@(posedge clock) disable iff (!nrst)
    (state_reg == FRC_OFF_WAIT && action_reg.retry == frc_pkg::RETRY_NONE && output_cmd_on && bias_ok)
    |=> state_reg != FRC_RETRY) else $error("retry with setting 000");

  // ======================================================================
  // Further checks: flag, readback, output drive and counters
  // They look at internal state as well as pins, so a failure points at
  // the step of the sequence that went wrong rather than at a symptom
  // far downstream on the output enable
  sequence s_retry_start;
    state_reg == FRC_OFF_WAIT ##1 (state_reg == FRC_RETRY && output_cmd_on && bias_ok);
  endsequence

  sequence s_expiry_with_fault;
    state_reg == FRC_DELAY_RUN && interval_done && fault_in && output_cmd_on && bias_ok && !other_shutdown;
  endsequence

  chk_notify_single: assert property (@(posedge clock) disable iff (!nrst)
    host_notify |=> !host_notify) else $error("host notification longer than one cycle");

  chk_flag_clears: assert property (@(posedge clock) disable iff (!nrst)
    (clear_faults && !fault_in) |=> !fault_flag) else $error("clear command ignored");

  chk_flag_resets: assert property (@(posedge clock) disable iff (!nrst)
    (clear_event && fault_in) |=> fault_flag) else $error("flag not set again at clear");

  chk_bias_clears: assert property (@(posedge clock) disable iff (!nrst)
    (!bias_ok && !fault_in) |=> !fault_flag) else $error("bias loss did not clear flag");

  chk_readback: assert property (@(posedge clock) disable iff (!nrst)
    action_wr |=> ##1 (action_rdata == $past(action_wdata, 2))) else $error("readback differs from write");

  chk_ignore_keeps: assert property (@(posedge clock) disable iff (!nrst)
    (state_reg == FRC_RUN && action_reg.resp == frc_pkg::RESP_IGNORE && output_cmd_on && bias_ok)
    |=> output_enable) else $error("response 00 dropped the output");

  chk_delay_enters: assert property (@(posedge clock) disable iff (!nrst)
    (state_reg == FRC_RUN && fault_rise && action_reg.resp == frc_pkg::RESP_DELAY_OFF
     && output_cmd_on && bias_ok && !other_shutdown) |=> state_reg == FRC_DELAY_RUN)
    else $error("response 01 did not start the delay");

  chk_delay_keeps: assert property (@(posedge clock) disable iff (!nrst)
    (state_reg == FRC_DELAY_RUN && output_cmd_on && bias_ok) |=> output_enable)
    else $error("output dropped during delay");

  chk_delay_latches: assert property (@(posedge clock) disable iff (!nrst)
    s_expiry_with_fault |=> state_reg == FRC_LATCHED) else $error("no latch at delay expiry");

  chk_latched_dark: assert property (@(posedge clock) disable iff (!nrst)
    state_reg == FRC_LATCHED |=> !output_enable) else $error("output on while latched");

  chk_shutdown_enters: assert property (@(posedge clock) disable iff (!nrst)
    (state_reg == FRC_RUN && fault_rise && action_reg.resp == frc_pkg::RESP_SHUTDOWN
     && output_cmd_on && bias_ok && !other_shutdown) |=> state_reg == FRC_OFF_WAIT)
    else $error("response 10 did not shut down");

  chk_wait_dark: assert property (@(posedge clock) disable iff (!nrst)
    state_reg == FRC_OFF_WAIT |=> !output_enable) else $error("output on between attempts");

  chk_inhibit_enters: assert property (@(posedge clock) disable iff (!nrst)
    (state_reg == FRC_RUN && fault_rise && action_reg.resp == frc_pkg::RESP_INHIBIT
     && output_cmd_on && bias_ok && !other_shutdown) |=> state_reg == FRC_INHIBIT)
    else $error("response 11 did not inhibit");

  chk_inhibit_dark: assert property (@(posedge clock) disable iff (!nrst)
    state_reg == FRC_INHIBIT |=> !output_enable) else $error("output on while inhibited");

  chk_attempt_drives: assert property (@(posedge clock) disable iff (!nrst)
    s_retry_start |=> output_enable) else $error("restart attempt left output off");

  chk_attempt_ends: assert property (@(posedge clock) disable iff (!nrst)
    (state_reg == FRC_RETRY && output_cmd_on && bias_ok && !other_shutdown)
    |=> (state_reg == FRC_OFF_WAIT || state_reg == FRC_RUN)) else $error("attempt outcome lost");

  chk_cmd_off_stops: assert property (@(posedge clock) disable iff (!nrst)
    (!output_cmd_on || !bias_ok) |=> (!output_enable && state_reg == FRC_RUN))
    else $error("off command or bias loss ignored");

  chk_other_latches: assert property (@(posedge clock) disable iff (!nrst)
    (other_shutdown && output_cmd_on && bias_ok) |=> state_reg == FRC_LATCHED)
    else $error("other fault did not shut down");

  chk_count_reload: assert property (@(posedge clock) disable iff (!nrst)
    ((fault_rise || state_reg == FRC_RETRY) && !action_wr) |=> unit_cnt_reg == action_reg.delay)
    else $error("delay counter not reloaded");

  chk_tick_single: assert property (@(posedge clock) disable iff (!nrst)
    (tick && UNIT_CYCLES > 1) |=> !tick) else $error("delay unit tick too long");

endmodule

// [dv/frc_host_model.sv]
// Host-side model: response byte writes, fault condition and control inputs
`timescale 1ns/1ps
module frc_host_model (
  input wire logic clock,
  output logic action_wr,
  output logic [7:0] action_wdata,
  output logic fault_in,
  output logic other_shutdown,
  output logic clear_faults,
  output logic output_cmd_on,
  output logic bias_ok
);
  // ======================================================================
  // Idle levels: output commanded on, bias present, no fault
  initial begin
    action_wr = 1'b0;
    action_wdata = 8'h00;
    fault_in = 1'b0;
    other_shutdown = 1'b0;
    clear_faults = 1'b0;
    output_cmd_on = 1'b1;
    bias_ok = 1'b1;
  end
  // Whole byte in one strobe; released data shows its inverse, never the old value
  task automatic put_action(input logic [7:0] b);
    @(negedge clock);
    action_wr = 1'b1;
    action_wdata = b;
    @(negedge clock);
    action_wr = 1'b0;
    action_wdata = ~b;
  endtask
  // Fault level changes off the sampling edge
  task automatic set_fault(input logic v);
    @(negedge clock);
    fault_in = v;
  endtask
  // One-cycle clear command
  task automatic pulse_clear();
    @(negedge clock);
    clear_faults = 1'b1;
    @(negedge clock);
    clear_faults = 1'b0;
  endtask
  // Off then on again: the restart permission
  task automatic off_on();
    @(negedge clock);
    output_cmd_on = 1'b0;
    repeat (2) @(negedge clock);
    output_cmd_on = 1'b1;
  endtask
  // Level changes of the remaining controls, off the sampling edge
  task automatic set_other(input logic v);
    @(negedge clock);
    other_shutdown = v;
  endtask
  task automatic set_cmd(input logic v);
    @(negedge clock);
    output_cmd_on = v;
  endtask
  task automatic set_bias(input logic v);
    @(negedge clock);
    bias_ok = v;
  endtask
endmodule

// [dv/testbench.sv]
// Self-checking bench for the fault response sequencer
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin errors++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module testbench;
  localparam int UNIT = 4;
  logic clock;
  logic nrst;
  wire logic action_wr;
  wire logic [7:0] action_wdata;
  wire logic fault_in;
  wire logic other_shutdown;
  wire logic clear_faults;
  wire logic output_cmd_on;
  wire logic bias_ok;
  wire logic [7:0] action_rdata;
  wire logic fault_flag;
  wire logic host_notify;
  wire logic output_enable;
  wire logic latched_off;
  int errors = 0;
  int n_compared = 0;
  int i;
  int n_on;
  int last_on;
  // ======================================================================
  // Clock and reset; short delay unit keeps the run brief
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  frc_fault_response #(
    .UNIT_CYCLES(UNIT)
  ) frc_fault_response_inst (
    .clock(clock),
    .nrst(nrst),
    .action_wr(action_wr),
    .action_wdata(action_wdata),
    .fault_in(fault_in),
    .other_shutdown(other_shutdown),
    .clear_faults(clear_faults),
    .output_cmd_on(output_cmd_on),
    .bias_ok(bias_ok),
    .action_rdata(action_rdata),
    .fault_flag(fault_flag),
    .host_notify(host_notify),
    .output_enable(output_enable),
    .latched_off(latched_off)
  );
  frc_host_model frc_host_model_inst (
    .clock(clock),
    .action_wr(action_wr),
    .action_wdata(action_wdata),
    .fault_in(fault_in),
    .other_shutdown(other_shutdown),
    .clear_faults(clear_faults),
    .output_cmd_on(output_cmd_on),
    .bias_ok(bias_ok)
  );
  // ======================================================================
  // Bounded wait on output_enable (sel 0) or latched_off (sel 1)
  task automatic wait_out(input int sel, input logic v, input int n);
    int k;
    for (k = 0; k < n && (sel ? latched_off : output_enable) !== v; k++) @(negedge clock);
    `CHK(sel ? latched_off : output_enable, v)
    if ((sel ? latched_off : output_enable) !== v) close_out();
  endtask
  // Back to a clean running state between tests
  task automatic restore(input string name);
    frc_host_model_inst.set_fault(1'b0);
    frc_host_model_inst.off_on();
    frc_host_model_inst.pulse_clear();
    repeat (4) @(negedge clock);
    $display("TB: test %s done", name);
  endtask
  task automatic close_out();
    $display("TB: compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Hang guard: overrunning counts as a mismatch
  initial begin
    repeat (100000) @(posedge clock);
    errors++;
    close_out();
  end
  // ======================================================================
  // Main sequence
  initial begin
    nrst = 1'b0;
    repeat (5) @(negedge clock);
    nrst = 1'b1;
    `CHK(action_rdata, frc_pkg::ACTION_RESET)
    `CHK(fault_flag, 1'b0)
    frc_host_model_inst.put_action(8'h3f);
    @(negedge clock);
    `CHK(action_rdata, 8'h3f)
    // Response 00: flag and notify, output never interrupted
    frc_host_model_inst.put_action(8'h00);
    frc_host_model_inst.set_fault(1'b1);
    @(negedge clock);
    `CHK(fault_flag, 1'b1)
    `CHK(host_notify, 1'b1)
    for (i = 0; i < 20; i++) begin
      @(negedge clock);
      `CHK(output_enable, 1'b1)
    end
    frc_host_model_inst.pulse_clear();
    repeat (2) @(negedge clock);
    `CHK(fault_flag, 1'b1)
    frc_host_model_inst.set_fault(1'b0);
    repeat (3) @(negedge clock);
    `CHK(fault_flag, 1'b1)
    frc_host_model_inst.pulse_clear();
    repeat (2) @(negedge clock);
    `CHK(fault_flag, 1'b0)
    restore("ignore");
    // Response 11: off only while the fault lasts
    frc_host_model_inst.put_action(8'hc0);
    frc_host_model_inst.set_fault(1'b1);
    wait_out(0, 1'b0, 5);
    frc_host_model_inst.set_fault(1'b0);
    wait_out(0, 1'b1, 5);
    restore("inhibit");
    // Response 01, two units: runs, then latches off and stays off
    frc_host_model_inst.put_action(8'h42);
    frc_host_model_inst.set_fault(1'b1);
    repeat (3) @(negedge clock);
    `CHK(output_enable, 1'b1)
    wait_out(1, 1'b1, 40);
    frc_host_model_inst.set_fault(1'b0);
    repeat (20) @(negedge clock);
    `CHK(output_enable, 1'b0)
    frc_host_model_inst.off_on();
    wait_out(0, 1'b1, 10);
    restore("delayed");
    // Response 10, no retry: off at once, no restart
    frc_host_model_inst.put_action(8'h81);
    frc_host_model_inst.set_fault(1'b1);
    wait_out(0, 1'b0, 3);
    frc_host_model_inst.set_fault(1'b0);
    repeat (40) @(negedge clock);
    `CHK(output_enable, 1'b0)
    restore("no_retry");
    // Six attempts against a persisting fault, then latched off
    frc_host_model_inst.put_action(8'hb1);
    frc_host_model_inst.set_fault(1'b1);
    repeat (2) @(negedge clock);
    n_on = 0;
    last_on = 0;
    // Each attempt is a one-cycle enable; attempts one delay unit apart
    for (i = 0; i < 200 && latched_off !== 1'b1; i++) begin
      @(negedge clock);
      if (i == 10) `CHK(latched_off, 1'b0)
      if (output_enable === 1'b1) begin
        if (n_on > 0) `CHK(i - last_on, UNIT)
        n_on++;
        last_on = i;
      end
    end
    `CHK(n_on, 6)
    wait_out(1, 1'b1, 200);
    restore("retry6");
    // Endless retry never latches on its own; an off command, bias loss or another fault's shutdown stops it
    frc_host_model_inst.put_action(8'hb9);
    frc_host_model_inst.set_fault(1'b1);
    repeat (200) @(negedge clock);
    `CHK(latched_off, 1'b0)
    // Another fault's shutdown ends endless retry, then an off command frees the latch
    frc_host_model_inst.set_other(1'b1);
    wait_out(1, 1'b1, 4);
    frc_host_model_inst.set_other(1'b0);
    frc_host_model_inst.set_cmd(1'b0);
    wait_out(0, 1'b0, 3);
    wait_out(1, 1'b0, 3);
    restore("endless");
    // Reset in mid-run clears the flag and restores the setting
    frc_host_model_inst.put_action(8'h00);
    frc_host_model_inst.set_fault(1'b1);
    frc_host_model_inst.set_fault(1'b0);
    `CHK(fault_flag, 1'b1)
    @(negedge clock);
    nrst = 1'b0;
    repeat (2) @(negedge clock);
    nrst = 1'b1;
    `CHK(fault_flag, 1'b0)
    `CHK(action_rdata, frc_pkg::ACTION_RESET)
    @(negedge clock);
    `CHK(output_enable, 1'b1)
    restore("reset");
    // Bias loss clears a latched flag
    frc_host_model_inst.put_action(8'h00);
    frc_host_model_inst.set_fault(1'b1);
    frc_host_model_inst.set_fault(1'b0);
    `CHK(fault_flag, 1'b1)
    frc_host_model_inst.set_bias(1'b0);
    repeat (2) @(negedge clock);
    `CHK(fault_flag, 1'b0)
    `CHK(output_enable, 1'b0)
    frc_host_model_inst.set_bias(1'b1);
    restore("bias");
    close_out();
  end
endmodule
